// >>> logic/srpc_consts.svh
// constants for the sdram refresh and power control block
// assumes a single 25 MHz clock and a plain strobe register port
// How it works
// R1: burst issues burst count plus one refreshes
// R2: interval field counts clocks between refresh requests
// R3: interval counter reloads and raises request on expiry
// R4: zero interval means no periodic refresh
// R5: mode 000 disable, 010 normal, 011 stand-by
// R6: mode 100 puts memory in self-refresh
// R7: pending counter caps at seven, overflow sticky
// R8: state reads 001 disabled, 000 normal
// R9: state reads 010 self-refresh, 100 stand-by
// R10: status register ignores all writes
// R11: writing one to clear bit 3 clears overflow
// R12: clear register reads back zero
// R13: control register resets to zero
// R14: status register resets to one
// R15: each refresh command lasts cycle length plus one
// R16: serviced burst decrements pending count, never wraps
// R17: mode changes only at a command boundary
`ifndef SRPC_CONSTS_SVH
`define SRPC_CONSTS_SVH
`define SRPC_ADDR_CTRL 4'h0
`define SRPC_ADDR_STATUS 4'h4
`define SRPC_ADDR_CLEAR 4'h8
`define SRPC_ADDR_IRQ_STATUS 4'hC
`define SRPC_ADDR_IRQ_MASK 4'h1
`define SRPC_CTRL_RESET 32'h00000000
`define SRPC_BURST_HI 31
`define SRPC_BURST_LO 28
`define SRPC_INTERVAL_HI 27
`define SRPC_INTERVAL_LO 16
`define SRPC_CYCLE_HI 14
`define SRPC_CYCLE_LO 12
`define SRPC_MODE_HI 2
`define SRPC_MODE_LO 0
`define SRPC_OVF_BIT 3
`define SRPC_PENDING_MAX 3'h7
`define SRPC_MODE_DISABLE 3'h0
`define SRPC_MODE_NORMAL 3'h2
`define SRPC_MODE_STANDBY 3'h3
`define SRPC_MODE_SELFREF 3'h4
`define SRPC_STATE_DISABLED 3'h1
`define SRPC_STATE_NORMAL 3'h0
`define SRPC_STATE_SELFREF 3'h2
`define SRPC_STATE_STANDBY 3'h4
`define SRPC_IRQ_OVF 0
`define SRPC_IRQ_REQ 1
`endif

// >>> logic/srpc_pkg.sv
// types for the sdram refresh and power control block
// assumes srpc_consts.svh is available on the include path
package srpc_pkg;
  typedef enum logic [1:0] {
    SRPC_IDLE = 2'b00,
    SRPC_REFRESH = 2'b01,
    SRPC_ACCESS = 2'b10
  } srpc_seq_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } srpc_bus_t;
  typedef struct packed {
    logic refresh_cmd;
    logic self_refresh;
    logic standby;
    logic enable;
  } srpc_mem_t;
endpackage

// >>> logic/srpc_top.sv
// sdram refresh scheduler, power mode control and status registers
// assumes a synchronous register port and a memory sequencer that
// reports access activity and takes one refresh command pulse at a time
`include "srpc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module srpc_top
  import srpc_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // register port
  input wire srpc_bus_t bus_in,
  output logic [31:0] rdata_out,
  // sequencer side
  input wire logic access_busy_in,
  output srpc_mem_t mem_out,
  // interrupt
  output logic irq_out
);
  ////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl_reg;
  logic ovf_reg;
  logic [2:0] mode_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  logic [11:0] interval_cnt_reg;
  logic [2:0] pending_reg;
  logic [3:0] burst_left_reg;
  logic [2:0] cycle_cnt_reg;
  logic [31:0] rdata_reg;
  logic refresh_cmd_reg;
  srpc_seq_t seq_reg;
  logic [2:0] state_field;
  logic req_pulse;
  logic service_done;
  logic wr_ctrl;
  logic wr_clear;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic [11:0] interval;
  logic [2:0] mode_field;
  assign wr_ctrl = bus_in.wr && (bus_in.addr == `SRPC_ADDR_CTRL);
  assign wr_clear = bus_in.wr && (bus_in.addr == `SRPC_ADDR_CLEAR);
  assign wr_irq_status = bus_in.wr && (bus_in.addr == `SRPC_ADDR_IRQ_STATUS);
  assign wr_irq_mask = bus_in.wr && (bus_in.addr == `SRPC_ADDR_IRQ_MASK);
  assign interval = ctrl_reg[`SRPC_INTERVAL_HI:`SRPC_INTERVAL_LO];
  assign mode_field = ctrl_reg[`SRPC_MODE_HI:`SRPC_MODE_LO];
  ////////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      ctrl_reg <= `SRPC_CTRL_RESET; // [R13]
    else if (wr_ctrl)
      ctrl_reg <= bus_in.wdata;
  end
  // applied mode waits for a command boundary
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      mode_reg <= `SRPC_MODE_DISABLE;
    else if (seq_reg == SRPC_IDLE && !access_busy_in)
      mode_reg <= ctrl_reg[`SRPC_MODE_HI:`SRPC_MODE_LO]; // [R17]
  end
  ////////////////////////////////////////////////////////////////////
  // refresh interval counter; counts whenever the interval is nonzero, in every mode
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      interval_cnt_reg <= 12'h000;
    else if (interval == 12'h000 || wr_ctrl)
      interval_cnt_reg <= 12'h000; // [R4]
    else if (interval_cnt_reg >= interval - 12'h001)
      interval_cnt_reg <= 12'h000; // [R3]
    else
      interval_cnt_reg <= interval_cnt_reg + 12'h001; // [R2]
  end
  assign req_pulse = (interval != 12'h000) && !wr_ctrl &&
    (interval_cnt_reg >= interval - 12'h001) &&
    (mode_reg == `SRPC_MODE_NORMAL || mode_reg == `SRPC_MODE_STANDBY); // [R4] [R6]
  // pending requests, saturating at seven
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      pending_reg <= 3'h0;
    else if (req_pulse && !service_done && pending_reg != `SRPC_PENDING_MAX)
      pending_reg <= pending_reg + 3'h1; // [R7]
    else if (service_done && !req_pulse)
      pending_reg <= pending_reg - 3'h1; // [R16]
  end
  // sticky overflow; a new overflow beats a same-cycle clear
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      ovf_reg <= 1'b0;
    else if (req_pulse && !service_done && pending_reg == `SRPC_PENDING_MAX)
      ovf_reg <= 1'b1; // [R7]
    else if (wr_clear && bus_in.wdata[`SRPC_OVF_BIT])
      ovf_reg <= 1'b0; // [R11]
  end
  ////////////////////////////////////////////////////////////////////
  // refresh burst sequencer, runs between memory accesses
  assign service_done = (seq_reg == SRPC_REFRESH) && (cycle_cnt_reg == 3'h0) &&
    (burst_left_reg == 4'h0); // [R16]
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      seq_reg <= SRPC_IDLE;
      burst_left_reg <= 4'h0;
      cycle_cnt_reg <= 3'h0;
      refresh_cmd_reg <= 1'b0;
    end
    else
    begin
      refresh_cmd_reg <= 1'b0;
      case (seq_reg)
        SRPC_IDLE:
        begin
          if (access_busy_in)
            seq_reg <= SRPC_ACCESS;
          // judged on the mode applied at this same edge, so a burst never
          // starts just as the controller is switched off [R17]
          else if (pending_reg != 3'h0 && (mode_field == `SRPC_MODE_NORMAL ||
                   mode_field == `SRPC_MODE_STANDBY))
          begin
            seq_reg <= SRPC_REFRESH;
            burst_left_reg <= ctrl_reg[`SRPC_BURST_HI:`SRPC_BURST_LO]; // [R1]
            cycle_cnt_reg <= ctrl_reg[`SRPC_CYCLE_HI:`SRPC_CYCLE_LO]; // [R15]
            refresh_cmd_reg <= 1'b1;
          end
        end
        SRPC_REFRESH:
        begin
          if (cycle_cnt_reg != 3'h0)
            cycle_cnt_reg <= cycle_cnt_reg - 3'h1; // [R15]
          else if (burst_left_reg != 4'h0)
          begin
            burst_left_reg <= burst_left_reg - 4'h1; // [R1]
            cycle_cnt_reg <= ctrl_reg[`SRPC_CYCLE_HI:`SRPC_CYCLE_LO];
            refresh_cmd_reg <= 1'b1;
          end
          else
            seq_reg <= SRPC_IDLE;
        end
        SRPC_ACCESS:
        begin
          if (!access_busy_in)
            seq_reg <= SRPC_IDLE;
        end
        default:
          seq_reg <= SRPC_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////
  // reported controller state
  always_comb
  begin
    case (mode_reg)
      `SRPC_MODE_NORMAL: state_field = `SRPC_STATE_NORMAL; // [R8]
      `SRPC_MODE_STANDBY: state_field = `SRPC_STATE_STANDBY; // [R9]
      `SRPC_MODE_SELFREF: state_field = `SRPC_STATE_SELFREF; // [R9]
      default: state_field = `SRPC_STATE_DISABLED; // [R8] [R14]
    endcase
  end
  assign mem_out.refresh_cmd = refresh_cmd_reg;
  assign mem_out.self_refresh = (mode_reg == `SRPC_MODE_SELFREF); // [R6]
  assign mem_out.standby = (mode_reg == `SRPC_MODE_STANDBY); // [R5]
  assign mem_out.enable = (mode_reg == `SRPC_MODE_NORMAL) ||
    (mode_reg == `SRPC_MODE_STANDBY); // [R5]
  ////////////////////////////////////////////////////////////////////
  // interrupt status: bit0 overflow, bit1 refresh request dropped into queue
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      irq_status_reg <= 2'h0;
    else
      irq_status_reg <= (irq_status_reg & ~(wr_irq_status ? bus_in.wdata[1:0] : 2'h0)) |
        {req_pulse, req_pulse && !service_done && pending_reg == `SRPC_PENDING_MAX};
  end
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      irq_mask_reg <= 2'h0;
    else if (wr_irq_mask)
      irq_mask_reg <= bus_in.wdata[1:0];
  end
  assign irq_out = |(irq_status_reg & irq_mask_reg);
  ////////////////////////////////////////////////////////////////////
  // read data one cycle after the strobe; status writes fall through [R10]
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      rdata_reg <= 32'h00000000;
    else if (!bus_in.rd)
      rdata_reg <= 32'h00000000;
    else if (bus_in.addr == `SRPC_ADDR_CTRL)
      rdata_reg <= ctrl_reg;
    else if (bus_in.addr == `SRPC_ADDR_STATUS)
      rdata_reg <= {28'h0000000, ovf_reg, state_field};
    else if (bus_in.addr == `SRPC_ADDR_IRQ_STATUS)
      rdata_reg <= {30'h00000000, irq_status_reg};
    else if (bus_in.addr == `SRPC_ADDR_IRQ_MASK)
      rdata_reg <= {30'h00000000, irq_mask_reg};
    else
      rdata_reg <= 32'h00000000; // [R12]
  end
  assign rdata_out = rdata_reg;
endmodule // srpc_top
`default_nettype wire

// >>> verif/srpc_asserts.sv
// port checker for srpc_top
// assumes a bind from the bench top; sees top ports only
`include "srpc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module srpc_asserts
  import srpc_pkg::*;
(
  // all top ports
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire srpc_bus_t bus_in,
  input wire logic [31:0] rdata_out,
  input wire logic access_busy_in,
  input wire srpc_mem_t mem_out,
  input wire logic irq_out
);
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  wire logic off_w = !(mem_out.enable || mem_out.self_refresh || mem_out.standby);
  sequence s_stat_rd;
    bus_in.rd && bus_in.addr == `SRPC_ADDR_STATUS;
  endsequence
  // state read back must match the mode levels of the read cycle
  property p_state(logic c, logic [2:0] v);
    s_stat_rd ##1 $past(c) |-> rdata_out[2:0] == v;
  endproperty
  AST_RST: assert property ($fell(reset_in) |-> !mem_out.enable && !irq_out)
    else $error("reset state wrong");
  AST_CLR_RD: assert property (bus_in.rd && bus_in.addr == `SRPC_ADDR_CLEAR |=> !rdata_out)
    else $error("clear read not zero");
  AST_DIS_CMD: assert property (!mem_out.enable |-> !mem_out.refresh_cmd)
    else $error("refresh while disabled");
  AST_SELF_CMD: assert property (mem_out.self_refresh |-> !mem_out.refresh_cmd)
    else $error("refresh in self-refresh");
  AST_ST_DIS: assert property (p_state(off_w, 3'h1))
    else $error("disabled state code");
  AST_ST_SELF: assert property (p_state(mem_out.self_refresh, 3'h2))
    else $error("self-refresh state code");
  AST_ST_STBY: assert property (p_state(mem_out.standby && !mem_out.self_refresh, 3'h4))
    else $error("stand-by state code");
  // two busy samples leave no idle slot for a mode change
  AST_HOLD: assert property ($past(access_busy_in) && $past(access_busy_in, 2) |-> $stable(mem_out[2:0]))
    else $error("mode changed during access");
endmodule // srpc_asserts
`default_nettype wire

// >>> verif/srpc_seq_model.sv
// memory sequencer stand-in driving access activity
// assumes one clock shared with srpc_top
`timescale 1ns/1ps
`default_nettype none
module srpc_seq_model
(
  // clock and control
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic traffic_in,
  // activity
  output logic access_busy_out
);
  ////////////////////////////////////////////////////////////
  logic [2:0] phase_reg;
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      phase_reg <= 3'h0;
    else
      phase_reg <= phase_reg + 3'h1;
  end
  // three busy cycles in eight, idle gaps let refresh and mode changes in
  assign access_busy_out = traffic_in && phase_reg < 3'h3;
endmodule // srpc_seq_model
`default_nettype wire

// >>> verif/test_sdram_refresh_power_control.sv
// self-checking bench for srpc_top with sequencer model
// assumes mask register at offset 0x1 as handed over
`include "srpc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module test_sdram_refresh_power_control
  import srpc_pkg::*;
;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  srpc_bus_t bus_in = '0;
  logic [31:0] rdata_out;
  logic access_busy_in;
  srpc_mem_t mem_out;
  logic irq_out;
  logic traffic = 1'b0;
  logic [31:0] seed = 32'h0000005C;
  logic [2:0] modes [5] = '{3'h2, 3'h3, 3'h4, 3'h0, 3'h7};
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  ////////////////////////////////////////////////////////////
  initial forever #20 mclk_in = ~mclk_in;
  always @(posedge mclk_in) cyc <= cyc + 1;
  srpc_top srpc_top_i (.mclk_in(mclk_in), .reset_in(reset_in), .bus_in(bus_in),
    .rdata_out(rdata_out), .access_busy_in(access_busy_in), .mem_out(mem_out), .irq_out(irq_out));
  srpc_seq_model srpc_seq_model_i (.mclk_in(mclk_in), .reset_in(reset_in),
    .traffic_in(traffic), .access_busy_out(access_busy_in));
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [31:0] ctl(logic [3:0] b, logic [11:0] i, logic [2:0] c, logic [2:0] m);
    return {b, i, 1'b0, c, 9'h000, m};
  endfunction
  function logic [31:0] st(logic [2:0] m);
    case (m)
      `SRPC_MODE_NORMAL: return 32'(`SRPC_STATE_NORMAL);
      `SRPC_MODE_STANDBY: return 32'(`SRPC_STATE_STANDBY);
      `SRPC_MODE_SELFREF: return 32'(`SRPC_STATE_SELFREF);
      default: return 32'(`SRPC_STATE_DISABLED);
    endcase
  endfunction
  task print_verdict();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask
  task wr(logic [3:0] a, logic [31:0] d);
    @(posedge mclk_in);
    bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_in);
    bus_in.wr <= 1'b0;
  endtask
  task rd(logic [3:0] a, logic [31:0] m, logic [31:0] e);
    @(posedge mclk_in);
    bus_in <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_in);
    bus_in.rd <= 1'b0;
    #1 chk("rdata", e, rdata_out & m);
  endtask
  // bounded watch for one command pulse, returns its cycle
  task automatic wait_pulse(output int t);
    int n;
    n = 0;
    do
    begin
      @(posedge mclk_in);
      #1 n++;
    end
    while (mem_out.refresh_cmd !== 1'b1 && n < 2000);
    t = cyc;
    if (n >= 2000)
    begin
      num_errors++;
      print_verdict();
    end
  endtask
  initial
  begin
    logic [3:0] b;
    logic [11:0] iv;
    logic [2:0] c;
    logic [2:0] m;
    int t0, t1, tp, n;
    repeat (6) @(posedge mclk_in);
    reset_in <= 1'b0;
    rd(`SRPC_ADDR_STATUS, 32'hFFFFFFFF, 32'h1);
    rd(`SRPC_ADDR_CTRL, 32'hFFFFFFFF, `SRPC_CTRL_RESET);
    rd(`SRPC_ADDR_CLEAR, 32'hFFFFFFFF, 32'h0);
    rd(4'hF, 32'hFFFFFFFF, 32'h0);
    wr(`SRPC_ADDR_STATUS, rnd());
    rd(`SRPC_ADDR_STATUS, 32'hFFFFFFFF, 32'h1);
    traffic <= 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      wr(`SRPC_ADDR_CTRL, ctl(4'h0, 12'h0, 3'h0, modes[k]));
      repeat (12) @(posedge mclk_in);
      rd(`SRPC_ADDR_STATUS, 32'h7, st(modes[k]));
    end
    traffic <= 1'b0;
    repeat (3)
    begin
      // refresh off first so no stale burst is measured
      wr(`SRPC_ADDR_CTRL, ctl(4'h0, 12'h0, 3'h0, 3'h2));
      repeat (40) @(posedge mclk_in);
      b = 4'(rnd() % 4);
      c = 3'(rnd());
      iv = 12'(40 + rnd() % 40);
      m = 3'h2 + 3'(rnd() % 2);
      wr(`SRPC_ADDR_CTRL, ctl(b, iv, c, m));
      rd(`SRPC_ADDR_CTRL, 32'hFFFFFFFF, ctl(b, iv, c, m));
      wait_pulse(t0);
      tp = t0;
      for (int k = 0; k < b; k++)
      begin
        wait_pulse(t1);
        chk("spacing", 32'(c) + 1, t1 - tp);
        tp = t1;
      end
      wait_pulse(t1);
      chk("period", 32'(iv), t1 - t0);
    end
    wr(`SRPC_ADDR_CTRL, ctl(4'h0, 12'h0, 3'h0, 3'h2));
    repeat (40) @(posedge mclk_in);
    n = 0;
    repeat (300)
    begin
      @(posedge mclk_in);
      #1 n += mem_out.refresh_cmd;
    end
    chk("idle cmds", 0, n);
    traffic <= 1'b1;
    wr(`SRPC_ADDR_CTRL, ctl(4'hF, 12'h2, 3'h7, 3'h3));
    repeat (60) @(posedge mclk_in);
    rd(`SRPC_ADDR_STATUS, 32'h8, 32'h8);
    wr(4'h1, 32'h1);
    repeat (2) @(posedge mclk_in);
    #1 chk("irq", 1, irq_out);
    wr(4'h1, 32'h0);
    repeat (2) @(posedge mclk_in);
    #1 chk("irq masked", 0, irq_out);
    wr(`SRPC_ADDR_CLEAR, 32'hFFFFFFF7);
    rd(`SRPC_ADDR_STATUS, 32'h8, 32'h8);
    wr(`SRPC_ADDR_CTRL, 32'h0);
    repeat (200) @(posedge mclk_in);
    wr(`SRPC_ADDR_CLEAR, 32'h8);
    rd(`SRPC_ADDR_STATUS, 32'hFFFFFFFF, 32'h1);
    wr(4'h1, 32'h1);
    wr(`SRPC_ADDR_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge mclk_in);
    #1 chk("irq cleared", 0, irq_out);
    print_verdict();
  end
endmodule // test_sdram_refresh_power_control
bind srpc_top srpc_asserts srpc_asserts_i (.mclk_in(mclk_in), .reset_in(reset_in),
  .bus_in(bus_in), .rdata_out(rdata_out), .access_busy_in(access_busy_in),
  .mem_out(mem_out), .irq_out(irq_out));
`default_nettype wire
